// file: inc/adc_cfg_pkg.sv
// Constants, types and register map of the converter configuration bank.
// Assumes a single 10 MHz ref_clk domain; every SPI pin is sampled on it.
package adc_cfg_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int HDR_BITS = 16;
  localparam int NUM_REGS = 24;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] byte_t;

  localparam addr_t ADDR_LAST = 10'h15d;
  localparam addr_t ADDR_MAX = 10'h3ff;

  localparam int POR_DELAY_CYCLES = 1 << 20;

  // Instruction header layout
  localparam int HDR_RW_BIT = 15;
  localparam int HDR_LEN_HI = 14;
  localparam int HDR_LEN_LO = 13;
  localparam int HDR_DEV_HI = 12;
  localparam int HDR_DEV_LO = 10;
  localparam int HDR_ADDR_HI = 9;
  localparam logic [1:0] LEN_CONTINUOUS = 2'h3;
  localparam logic DEV_A2_FIXED = 1'h0;

  localparam logic [3:0] HDR_LAST_BIT = 4'hf;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  // Mode byte: upper copy of each field and its mirrored lower copy
  localparam int MODE_SHUTDOWN_HI = 7;
  localparam int MODE_LSB_HI = 6;
  localparam int MODE_SRST_HI = 5;
  localparam int MODE_STBY_HI = 4;
  localparam int MODE_STBY_LO = 3;
  localparam int MODE_SRST_LO = 2;
  localparam int MODE_LSB_LO = 1;
  localparam int MODE_SHUTDOWN_LO = 0;

  // Entry indices of registers whose fields leave the bank
  localparam int IDX_MODE = 0;
  localparam int IDX_CHAN = 1;
  localparam int IDX_RATE = 2;
  localparam int IDX_SDO = 3;
  localparam int IDX_SCRAMBLE = 4;
  localparam int IDX_AUTOCAL = 5;
  localparam int IDX_OFFSET_LO = 23;
  localparam int BIT_IND_RATE = 7;
  localparam int BIT_SDO_EDGE = 7;
  localparam int BIT_WCK_POL = 7;

  // Defaults of 0x54 and 0x58 are not given; value is arbitrary
  localparam byte_t DFLT_REF_DIV_LOW = 8'h00;
  localparam byte_t DFLT_CHARGE_PUMP = 8'h00;

  localparam addr_t REG_ADDR [NUM_REGS] = '{
    10'h000, 10'h001, 10'h002, 10'h004, 10'h007, 10'h01e,
    10'h052, 10'h053, 10'h054, 10'h055, 10'h056, 10'h057,
    10'h058, 10'h059, 10'h05a, 10'h05b, 10'h05c, 10'h05d,
    10'h05f, 10'h062, 10'h063, 10'h064, 10'h065, 10'h066};

  localparam byte_t REG_DEFAULT [NUM_REGS] = '{
    8'h24, 8'h0f, 8'h00, 8'h9f, 8'h62, 8'h80,
    8'h0a, 8'h45, DFLT_REF_DIV_LOW, 8'h48, 8'h78, 8'h40,
    DFLT_CHARGE_PUMP, 8'h41, 8'h2f, 8'h27, 8'h27, 8'h27,
    8'hf1, 8'h10, 8'h01, 8'h03, 8'h00, 8'h00};

  localparam byte_t REG_IMPL_MASK [NUM_REGS] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h7f,
    8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff};

  // Read-only registers sit at the top of the map, beyond this bank
  localparam logic [NUM_REGS-1:0] REG_READ_ONLY = 24'h000000;

endpackage

// file: rtl/por_init_timer.sv
// Power-on delay counter that triggers the first default load.
// Assumes rst is the power-on reset, asynchronous and active high.
`timescale 1ns/10ps
module por_init_timer #(
  parameter int DELAY_CYCLES = adc_cfg_pkg::POR_DELAY_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  output logic init_load,
  output logic init_done
);
  import adc_cfg_pkg::*;

  localparam int CNT_W = $clog2(DELAY_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DELAY_CYCLES - 1);

  logic [CNT_W-1:0] cnt_r;
  logic done_r;
  wire at_last = (cnt_r == CNT_LAST);

  assign init_load = !done_r && at_last;
  assign init_done = done_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else if (!done_r) begin
      cnt_r <= cnt_r + 1'b1;
      done_r <= at_last;
    end
  end

endmodule

// file: rtl/cfg_reg_entry.sv
// One eight-bit configuration register with default, mask and access mode.
// Assumes the caller has already decoded the address into wr_en.
`timescale 1ns/10ps
module cfg_reg_entry #(
  parameter adc_cfg_pkg::byte_t DEFAULT = 8'h00,
  parameter adc_cfg_pkg::byte_t IMPL_MASK = 8'hff,
  parameter bit READ_ONLY = 1'b0,
  parameter bit MIRROR = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load_defaults,
  input wire logic wr_en,
  input wire adc_cfg_pkg::byte_t wr_data,
  output adc_cfg_pkg::byte_t q
);
  import adc_cfg_pkg::*;

  byte_t q_r;
  byte_t q_nxt;
  logic shut;
  logic lsb;
  logic srst_n;
  logic stby;

  assign shut = wr_data[MODE_SHUTDOWN_HI] | wr_data[MODE_SHUTDOWN_LO];
  assign lsb = wr_data[MODE_LSB_HI] | wr_data[MODE_LSB_LO];
  assign srst_n = wr_data[MODE_SRST_HI] & wr_data[MODE_SRST_LO];
  assign stby = wr_data[MODE_STBY_HI] | wr_data[MODE_STBY_LO];

  wire byte_t mirrored = {shut, lsb, srst_n, stby, stby, srst_n, lsb, shut};
  wire byte_t wr_value = MIRROR ? mirrored : wr_data;

  always_comb begin
    q_nxt = q_r;
    if (load_defaults) begin
      q_nxt = DEFAULT & IMPL_MASK;
    end else if (wr_en && !READ_ONLY) begin
      q_nxt = wr_value & IMPL_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q_r <= 8'h00;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

// file: rtl/adc_config_register_bank.sv
// Configuration register bank with its serial command front end.
// Assumes cs_n, sclk, sdio_in and the address straps are synchronous
// to ref_clk, and that sclk runs well below half the ref_clk rate.
`timescale 1ns/10ps
module adc_config_register_bank #(
  parameter int POR_DELAY = adc_cfg_pkg::POR_DELAY_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hw_reset_n,
  input wire logic dev_addr1,
  input wire logic dev_addr0,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic config_ready,
  output logic shutdown,
  output logic standby,
  output logic lsb_first,
  output logic soft_reset_n,
  output logic independent_rate_enable,
  output logic [3:0] output_word_rate,
  output logic [3:0] output_clock_rate,
  output logic serial_out_edge_select,
  output logic word_clock_polarity,
  output adc_cfg_pkg::byte_t autocal_delay_value,
  output adc_cfg_pkg::byte_t global_offset_value,
  output logic [adc_cfg_pkg::NUM_REGS-1:0][7:0] cfg_regs
);
  import adc_cfg_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HDR,
    ST_WRITE,
    ST_READ,
    ST_SKIP
  } frame_state_t;

  ////////////////////////////////////////////////////////////////////////
  // Initialisation

  logic por_load;
  logic por_done;

  por_init_timer #(
    .DELAY_CYCLES(POR_DELAY)
  ) u_por (
    .ref_clk(ref_clk),
    .rst(rst),
    .init_load(por_load),
    .init_done(por_done)
  );

  wire load_defaults = por_load | (por_done & !hw_reset_n);
  wire serial_enable = por_done & hw_reset_n;
  assign config_ready = serial_enable;

  ////////////////////////////////////////////////////////////////////////
  // Frame engine state

  frame_state_t state_r;
  frame_state_t state_nxt;
  logic [HDR_BITS-1:0] hdr_r;
  logic [HDR_BITS-1:0] hdr_nxt;
  byte_t rx_r;
  byte_t rx_nxt;
  byte_t tx_r;
  byte_t tx_nxt;
  logic [3:0] bit_r;
  logic [3:0] bit_nxt;
  addr_t addr_r;
  addr_t addr_nxt;
  logic [1:0] len_r;
  logic [1:0] len_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic last_r;
  logic last_nxt;
  logic sclk_q_r;
  logic sdo_r;
  logic sdo_nxt;
  logic oe_r;
  logic oe_nxt;
  logic wr_en_r;
  logic wr_en_nxt;
  byte_t wr_data_r;
  byte_t wr_data_nxt;
  byte_t rd_data;

  wire sclk_rise = !cs_n && sclk && !sclk_q_r;
  wire sclk_fall = !cs_n && !sclk && sclk_q_r;

  // Bit order follows the mode register for header and data alike
  wire [HDR_BITS-1:0] hdr_shift = lsb_first ?
    {sdio_in, hdr_r[HDR_BITS-1:1]} : {hdr_r[HDR_BITS-2:0], sdio_in};
  wire byte_t rx_shift = lsb_first ?
    {sdio_in, rx_r[7:1]} : {rx_r[6:0], sdio_in};
  wire byte_t tx_shift = lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
  wire tx_bit = lsb_first ? tx_r[0] : tx_r[7];
  wire byte_t rd_shift = lsb_first ?
    {1'b0, rd_data[7:1]} : {rd_data[6:0], 1'b0};
  wire rd_first_bit = lsb_first ? rd_data[0] : rd_data[7];

  wire [2:0] own_dev = {DEV_A2_FIXED, dev_addr1, dev_addr0};
  wire dev_match = (hdr_shift[HDR_DEV_HI:HDR_DEV_LO] == own_dev);
  wire hdr_read = hdr_shift[HDR_RW_BIT];
  wire [1:0] hdr_len = hdr_shift[HDR_LEN_HI:HDR_LEN_LO];
  wire addr_t hdr_addr = hdr_shift[HDR_ADDR_HI:0];
  wire byte_done = (bit_r[2:0] == BYTE_LAST_BIT);
  wire final_byte = (len_r != LEN_CONTINUOUS) && (cnt_r == len_r);

  wire addr_t addr_step = (addr_r == ADDR_MAX) ? addr_r :
    addr_t'(addr_r + 1'b1);

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencing

  always_comb begin
    state_nxt = state_r;
    hdr_nxt = hdr_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    bit_nxt = bit_r;
    addr_nxt = addr_r;
    len_nxt = len_r;
    cnt_nxt = cnt_r;
    last_nxt = last_r;
    sdo_nxt = sdo_r;
    oe_nxt = oe_r;
    wr_en_nxt = 1'b0;
    wr_data_nxt = wr_data_r;
    if (cs_n) begin
      state_nxt = ST_IDLE;
      oe_nxt = 1'b0;
      bit_nxt = 4'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          state_nxt = serial_enable ? ST_HDR : ST_SKIP;
          bit_nxt = 4'h0;
          cnt_nxt = 2'h0;
          last_nxt = 1'b0;
        end
        ST_HDR: begin
          if (sclk_rise) begin
            hdr_nxt = hdr_shift;
            bit_nxt = bit_r + 1'b1;
            if (bit_r == HDR_LAST_BIT) begin
              bit_nxt = 4'h0;
              addr_nxt = hdr_addr;
              len_nxt = hdr_len;
              if (!dev_match) begin
                state_nxt = ST_SKIP;
              end else if (hdr_read) begin
                state_nxt = ST_READ;
              end else begin
                state_nxt = ST_WRITE;
              end
            end
          end
        end
        ST_WRITE: begin
          if (sclk_rise) begin
            rx_nxt = rx_shift;
            bit_nxt = bit_r + 1'b1;
            if (byte_done) begin
              bit_nxt = 4'h0;
              wr_en_nxt = 1'b1;
              wr_data_nxt = rx_shift;
              addr_nxt = addr_step;
              cnt_nxt = cnt_r + 1'b1;
              if (final_byte) begin
                state_nxt = ST_SKIP;
              end
            end
          end
        end
        ST_READ: begin
          if (sclk_fall) begin
            if (bit_r == 4'h0) begin
              if (last_r) begin
                state_nxt = ST_SKIP;
                oe_nxt = 1'b0;
              end else begin
                sdo_nxt = rd_first_bit;
                tx_nxt = rd_shift;
                oe_nxt = 1'b1;
                bit_nxt = 4'h1;
              end
            end else begin
              sdo_nxt = tx_bit;
              tx_nxt = tx_shift;
              bit_nxt = bit_r + 1'b1;
              if (byte_done) begin
                bit_nxt = 4'h0;
                addr_nxt = addr_step;
                cnt_nxt = cnt_r + 1'b1;
                last_nxt = final_byte;
              end
            end
          end
        end
        ST_SKIP: begin
          oe_nxt = 1'b0;
        end
        default: begin
          state_nxt = ST_SKIP;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      hdr_r <= '0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      bit_r <= 4'h0;
      addr_r <= '0;
      len_r <= 2'h0;
      cnt_r <= 2'h0;
      last_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hdr_r <= hdr_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      bit_r <= bit_nxt;
      addr_r <= addr_nxt;
      len_r <= len_nxt;
      cnt_r <= cnt_nxt;
      last_r <= last_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_q_r <= 1'b0;
      sdo_r <= 1'b0;
      oe_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_data_r <= 8'h00;
    end else begin
      sclk_q_r <= sclk;
      sdo_r <= sdo_nxt;
      oe_r <= oe_nxt;
      wr_en_r <= wr_en_nxt;
      wr_data_r <= wr_data_nxt;
    end
  end

  assign sdio_out = sdo_r;
  assign sdio_oe = oe_r;

  ////////////////////////////////////////////////////////////////////////
  // Register array and decode

  // Write strobe is one cycle late, so it carries its own address
  addr_t wr_addr_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_addr_r <= '0;
    end else if (wr_en_nxt) begin
      wr_addr_r <= addr_r;
    end
  end

  wire rd_in_range = (addr_r <= ADDR_LAST);
  wire wr_in_range = (wr_addr_r <= ADDR_LAST);

  byte_t rd_chain [NUM_REGS+1];
  assign rd_chain[0] = 8'h00;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      wire rd_hit = rd_in_range && (addr_r == REG_ADDR[gi]);
      wire wr_hit = wr_en_r && wr_in_range && (wr_addr_r == REG_ADDR[gi]);
      cfg_reg_entry #(
        .DEFAULT(REG_DEFAULT[gi]),
        .IMPL_MASK(REG_IMPL_MASK[gi]),
        .READ_ONLY(REG_READ_ONLY[gi]),
        .MIRROR(gi == IDX_MODE)
      ) u_entry (
        .ref_clk(ref_clk),
        .rst(rst),
        .load_defaults(load_defaults),
        .wr_en(wr_hit),
        .wr_data(wr_data_r),
        .q(cfg_regs[gi])
      );
      assign rd_chain[gi+1] = rd_chain[gi] | (rd_hit ? cfg_regs[gi] : 8'h00);
    end
  endgenerate

  assign rd_data = rd_chain[NUM_REGS];

  ////////////////////////////////////////////////////////////////////////
  // Fields driven into the converter

  assign shutdown = cfg_regs[IDX_MODE][MODE_SHUTDOWN_HI];
  assign lsb_first = cfg_regs[IDX_MODE][MODE_LSB_HI];
  assign soft_reset_n = cfg_regs[IDX_MODE][MODE_SRST_HI];
  assign standby = cfg_regs[IDX_MODE][MODE_STBY_HI];
  assign independent_rate_enable = cfg_regs[IDX_CHAN][BIT_IND_RATE];
  assign output_word_rate = cfg_regs[IDX_RATE][7:4];
  assign output_clock_rate = cfg_regs[IDX_RATE][3:0];
  assign serial_out_edge_select = cfg_regs[IDX_SDO][BIT_SDO_EDGE];
  assign word_clock_polarity = cfg_regs[IDX_SCRAMBLE][BIT_WCK_POL];
  assign autocal_delay_value = cfg_regs[IDX_AUTOCAL];
  assign global_offset_value = cfg_regs[IDX_OFFSET_LO];

endmodule

// file: test/cfg_bank_monitor.sv
// Port assertions for the configuration register bank.
// Assumes it is bound into the bank top; one ref_clk domain.
`timescale 1ns/10ps
module cfg_bank_monitor #(
  parameter int POR_DELAY = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hw_reset_n,
  input wire logic cs_n,
  input wire logic sdio_oe,
  input wire logic config_ready,
  input wire logic shutdown,
  input wire logic standby,
  input wire logic lsb_first,
  input wire logic soft_reset_n,
  input wire logic [3:0] output_word_rate,
  input wire logic [3:0] output_clock_rate,
  input wire adc_cfg_pkg::byte_t autocal_delay_value,
  input wire adc_cfg_pkg::byte_t global_offset_value,
  input wire logic [adc_cfg_pkg::NUM_REGS-1:0][7:0] cfg_regs
);
  import adc_cfg_pkg::*;
  int unsigned cnt_r;
  logic [7:0] m;
  assign m = cfg_regs[IDX_MODE];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Edges since power-on release, saturating
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 0;
    end else if (cnt_r != POR_DELAY) begin
      cnt_r <= cnt_r + 1;
    end
  end
  por_hold_a: assert property (
    cnt_r < POR_DELAY |-> !config_ready && cfg_regs == '0)
    else $error("bank active before power-on delay");
  por_load_a: assert property (
    cnt_r == POR_DELAY && $past(cnt_r) == POR_DELAY - 1 |->
    config_ready && m == 8'h24 && cfg_regs[IDX_AUTOCAL] == 8'h80)
    else $error("defaults missing after power-on delay");
  hw_reset_a: assert property (
    cnt_r == POR_DELAY && !hw_reset_n |-> !config_ready ##1
    (cfg_regs[IDX_AUTOCAL] == 8'h80 && cfg_regs[IDX_OFFSET_LO] == 8'h00))
    else $error("reset pin did not load defaults");
  mode_mirror_a: assert property (
    m[3:0] == {m[4], m[5], m[6], m[7]})
    else $error("mode byte not mirrored");
  mode_out_a: assert property (
    {shutdown, lsb_first, soft_reset_n, standby} == m[7:4])
    else $error("mode outputs differ from register");
  fields_out_a: assert property (
    {output_word_rate, output_clock_rate} == cfg_regs[IDX_RATE] &&
    autocal_delay_value == cfg_regs[IDX_AUTOCAL] &&
    global_offset_value == cfg_regs[IDX_OFFSET_LO])
    else $error("field outputs differ from registers");
  unimpl_zero_a: assert property (
    !(cfg_regs[13][7] | cfg_regs[14][7] | cfg_regs[15][7] |
      cfg_regs[16][7] | cfg_regs[17][7] | cfg_regs[19][7]))
    else $error("unimplemented bit is set");
  regs_quiet_a: assert property (
    (cs_n && hw_reset_n && cnt_r == POR_DELAY) [*4] |-> $stable(cfg_regs))
    else $error("register changed without a frame");
  oe_start_a: assert property (
    $rose(sdio_oe) |-> !cs_n && config_ready)
    else $error("data driven outside a frame");
  oe_idle_a: assert property (
    cs_n && $past(cs_n) |-> !sdio_oe)
    else $error("data driven while deselected");
  cover property ($rose(config_ready) && cnt_r == POR_DELAY);
  cover property ($rose(sdio_oe));
  cover property (!hw_reset_n && cnt_r == POR_DELAY);
endmodule

// file: test/spi_host_model.sv
// Serial host that frames headers and data bytes, MSb first.
// Assumes sdio_oe high means the bank drives the shared line.
`timescale 1ns/10ps
module spi_host_model (
  input wire logic ref_clk,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  output logic cs_n,
  output logic sclk,
  output logic sdio_in
);
  logic drv = 1'b0;
  logic hold = 1'b1;
  logic tog = 1'b0;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
  end
  ////////////////////////////////////////
  // Released line toggles, no pull on it
  always @(posedge ref_clk) tog <= ~tog;
  assign sdio_in = sdio_oe ? sdio_out : (hold ? drv : tog);
  task automatic bit_cyc(input logic b, output logic r);
    @(posedge ref_clk);
    sclk <= 1'b0;
    drv <= b;
    repeat (3) @(posedge ref_clk);
    r = sdio_out;
    sclk <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic xfer(input logic [15:0] hdr, input int n,
      input logic [23:0] wd, output logic [23:0] rd);
    logic r;
    rd = '0;
    @(posedge ref_clk);
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) bit_cyc(hdr[i], r);
    if (hdr[15]) hold <= 1'b0;
    for (int i = n * 8 - 1; i >= 0; i--) begin
      bit_cyc(wd[i], r);
      rd[i] = r;
    end
    @(posedge ref_clk);
    sclk <= 1'b0;
    repeat (2) @(posedge ref_clk);
    cs_n <= 1'b1;
    hold <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask
endmodule

// file: test/adc_config_register_bank_tb.sv
// Self-checking bench for the configuration register bank.
// Assumes a shortened power-on delay and straps A1=0, A0=1.
`timescale 1ns/10ps
module adc_config_register_bank_tb;
  import adc_cfg_pkg::*;
  localparam int POR_N = 16;
  localparam logic [2:0] DEV = 3'h1;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hw_reset_n = 1'b1;
  logic cs_n, sclk, sdio_in, sdio_out, sdio_oe, config_ready;
  logic shutdown, standby, lsb_first, soft_reset_n;
  logic ind_rate, sdo_edge, wck_pol;
  logic [3:0] word_rate, clk_rate;
  byte_t autocal, offset;
  logic [NUM_REGS-1:0][7:0] regs;
  logic [23:0] rd;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #50 ref_clk = ~ref_clk;
  adc_config_register_bank #(.POR_DELAY(POR_N)) i_adc_config_register_bank (
    .ref_clk(ref_clk), .rst(rst), .hw_reset_n(hw_reset_n),
    .dev_addr1(1'b0), .dev_addr0(1'b1), .cs_n(cs_n), .sclk(sclk),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .config_ready(config_ready), .shutdown(shutdown), .standby(standby),
    .lsb_first(lsb_first), .soft_reset_n(soft_reset_n),
    .independent_rate_enable(ind_rate), .output_word_rate(word_rate),
    .output_clock_rate(clk_rate), .serial_out_edge_select(sdo_edge),
    .word_clock_polarity(wck_pol), .autocal_delay_value(autocal),
    .global_offset_value(offset), .cfg_regs(regs));
  spi_host_model i_spi_host_model (.ref_clk(ref_clk), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .cs_n(cs_n), .sclk(sclk), .sdio_in(sdio_in));
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
      miscompares++;
    end
  endtask
  function automatic logic [23:0] rev(input logic [23:0] v, input int w);
    logic [23:0] r;
    r = '0;
    for (int i = 0; i < w; i++) r[w - 1 - i] = v[i];
    return r;
  endfunction
  task automatic xfer(input logic rw, input logic [1:0] len,
      input logic [2:0] dev, input addr_t a, input int n,
      input logic [23:0] wd);
    i_spi_host_model.xfer({rw, len, dev, a}, n, wd, rd);
  endtask
  task automatic wr(input addr_t a, input byte_t d);
    xfer(1'b0, 2'h0, DEV, a, 1, {16'h0, d});
  endtask
  task automatic rd_chk(input addr_t a, input byte_t exp);
    xfer(1'b1, 2'h0, DEV, a, 1, 24'h0);
    chk(rd[7:0], exp);
  endtask
  task automatic test_por();
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (POR_N - 1) @(posedge ref_clk);
    #1;
    chk({7'h0, config_ready}, 8'h00);
    @(posedge ref_clk);
    #1;
    chk({7'h0, config_ready}, 8'h01);
    chk({5'h0, ind_rate, sdo_edge, wck_pol}, 8'h02);
    for (int i = 0; i < NUM_REGS; i++) chk(regs[i], REG_DEFAULT[i]);
  endtask
  task automatic test_rw();
    addr_t a [4] = '{10'h002, 10'h01e, 10'h056, 10'h066};
    foreach (a[i]) begin
      wr(a[i], 8'ha5 ^ byte_t'(i));
      rd_chk(a[i], 8'ha5 ^ byte_t'(i));
    end
    chk({word_rate, clk_rate}, 8'ha5);
    chk(autocal, 8'ha4);
    chk(offset, 8'ha6);
  endtask
  task automatic test_unmapped();
    rd_chk(10'h003, 8'h00);
    wr(10'h003, 8'hff);
    rd_chk(10'h003, 8'h00);
    rd_chk(10'h15d, 8'h00);
    rd_chk(10'h059, 8'h41);
    // Frame for another device on the bus
    xfer(1'b0, 2'h0, 3'h2, 10'h01e, 1, 24'h11);
    rd_chk(10'h01e, 8'ha4);
  endtask
  task automatic test_mode();
    wr(10'h000, 8'hbd);
    chk({4'h0, shutdown, standby, soft_reset_n, lsb_first}, 8'h0e);
    rd_chk(10'h000, 8'hbd);
    wr(10'h000, 8'h00);
    chk({7'h0, soft_reset_n}, 8'h00);
    wr(10'h000, 8'h24);
    chk({4'h0, shutdown, standby, soft_reset_n, lsb_first}, 8'h02);
  endtask
  task automatic test_lsb_first();
    logic [23:0] h;
    wr(10'h000, 8'h66);
    chk({7'h0, lsb_first}, 8'h01);
    // Header and data now travel LSb first
    h = rev({8'h00, 1'b0, 2'h0, DEV, 10'h01e}, 16);
    i_spi_host_model.xfer(h[15:0], 1, rev(24'h1e, 8), rd);
    chk(autocal, 8'h1e);
    h = rev({8'h00, 1'b1, 2'h0, DEV, 10'h01e}, 16);
    i_spi_host_model.xfer(h[15:0], 1, 24'h0, rd);
    h = rev(rd, 8);
    chk(h[7:0], 8'h1e);
    h = rev({8'h00, 1'b0, 2'h0, DEV, 10'h000}, 16);
    i_spi_host_model.xfer(h[15:0], 1, 24'h24, rd);
    chk({7'h0, lsb_first}, 8'h00);
  endtask
  task automatic test_burst();
    xfer(1'b0, 2'h3, DEV, 10'h065, 3, 24'h112233);
    xfer(1'b1, 2'h1, DEV, 10'h065, 2, 24'h0);
    chk(rd[15:8], 8'h11);
    chk(rd[7:0], 8'h22);
    xfer(1'b1, 2'h2, DEV, 10'h064, 3, 24'h0);
    chk(rd[23:16], 8'h03);
    chk(rd[15:8], 8'h11);
    chk(rd[7:0], 8'h22);
    xfer(1'b0, 2'h1, DEV, 10'h15d, 2, 24'h5566);
    chk(regs[IDX_MODE], 8'h24);
    chk(regs[IDX_CHAN], 8'h0f);
  endtask
  task automatic test_hw_reset();
    @(posedge ref_clk);
    hw_reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    hw_reset_n <= 1'b1;
    for (int i = 0; i < 20 && config_ready !== 1'b1; i++) @(posedge ref_clk);
    #1;
    for (int i = 0; i < NUM_REGS; i++) chk(regs[i], REG_DEFAULT[i]);
    rd_chk(10'h01e, 8'h80);
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    test_por();
    test_rw();
    test_unmapped();
    test_mode();
    test_lsb_first();
    test_burst();
    test_hw_reset();
    report_and_stop();
  end
endmodule
bind adc_config_register_bank cfg_bank_monitor #(.POR_DELAY(POR_DELAY))
  i_cfg_bank_monitor (.ref_clk(ref_clk), .rst(rst),
  .hw_reset_n(hw_reset_n), .cs_n(cs_n), .sdio_oe(sdio_oe),
  .config_ready(config_ready), .shutdown(shutdown), .standby(standby),
  .lsb_first(lsb_first), .soft_reset_n(soft_reset_n),
  .output_word_rate(output_word_rate),
  .output_clock_rate(output_clock_rate),
  .autocal_delay_value(autocal_delay_value),
  .global_offset_value(global_offset_value), .cfg_regs(cfg_regs));
